// ---- irq_lpm_cfg.svh ----
`ifndef IRQ_LPM_CFG_SVH
`define IRQ_LPM_CFG_SVH

// Register offsets of the plain register port (byte addresses).
`define SFR_IE1_ADDR      16'h0000
`define SFR_IE2_ADDR      16'h0001
`define CTL_MODE_ADDR     16'h0010
`define CTL_STATUS_ADDR   16'h0012
`define CTL_SOURCE_ADDR   16'h0014

// Field positions of the enable bytes at addresses zero and one.
`define IE1_WDT_BIT       0
`define IE1_OSC_BIT       1
`define IE1_NMI_BIT       4
`define IE1_ACCV_BIT      5
`define IE1_URX_BIT       6
`define IE1_UTX_BIT       7
`define IE2_BT_BIT        7

// Reset values.
`define IE1_RESET         8'h00
`define IE2_RESET         8'h00

// Vector table.
`define VEC_BASE          16'hFFE0
`define VEC_RESET         16'hFFFE

// Instruction fetch ranges that force a reset.
`define PERIPH_LO         16'h0000
`define PERIPH_HI         16'h01FF
`define UNUSED_LO         16'h0600
`define UNUSED_HI         16'h0BFF

`endif

// ---- irq_lpm_pkg.sv ----
package irq_lpm_pkg;

  // Operating modes, ordered from active down to the deepest sleep.
  typedef enum logic [2:0]
  {
    ACTIVE_STATE,
    SLEEP_MODE_ZERO,
    SLEEP_MODE_ONE,
    SLEEP_MODE_TWO,
    SLEEP_MODE_THREE,
    SLEEP_MODE_FOUR
  } op_mode_e;

  // Handshake states toward the CPU core.
  typedef enum logic [1:0]
  {
    IDLE,
    TAKING,
    IN_HANDLER
  } take_state_e;

  typedef logic [15:0] word_t;

endpackage

// ---- interrupt_vector_lowpower_ctl.sv ----
// Summary of operation
// - Vectors and start address occupy one word each from FFE0h to FFFFh.
// - Each vector slot holds a 16-bit handler address loaded into the PC.
// - All reset sources use vector FFFEh at top priority 15.
// - External NMI, oscillator fault, flash access violation share FFFCh at 14.
// - Priority-14 sources obey own enables; global enable does not gate them.
// - Mailbox uses FFFAh priority 13; converter uses FFF8h priority 12.
// - Capture channel 0 uses FFECh; channels 1, 2 and overflow share FFEAh.
// - Port 1 pin flags share FFE8h; port 2 pin flags share FFE2h.
// - Instruction fetch from 0h-1FFh or 600h-BFFh forces a reset.
// - Shared vectors keep source flags readable for the handler.
// - Marked sources keep their flags inside the originating peripheral.
// - One active mode and five software-selected low-power modes exist.
// - Interrupt wakes any low-power mode; return restores that mode.
// - In active mode every clock runs.
// - Mode zero halts CPU; auxiliary, sub-main, main and loop control run.
// - Mode one is mode zero with loop control stopped.
// - Mode two stops CPU, main and sub-main clocks, loop, osc output; bias and aux run.
// - Mode three is mode two with the bias generator also off.
// - Mode four stops all clocks, bias generator and the crystal oscillator.
// - Unassigned special-function bits hold no storage; enables sit lowest.
// - Byte 0h holds oscillator, NMI and flash violation enables, reset zero.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "irq_lpm_cfg.svh"

module interrupt_vector_lowpower_ctl
  import irq_lpm_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // Register port.
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // Reset sources (same clock domain, one-cycle or level).
  input  wire logic        POWER_UP_EVT,
  input  wire logic        EXT_RESET_REQ,
  input  wire logic        WATCHDOG_EXPIRY_FLAG,
  input  wire logic        FLASH_KEY_VIOLATION_FLAG,
  // Non-maskable group, levels from the peripherals.
  input  wire logic        EXT_NONMASK_REQ_FLAG,
  input  wire logic        OSC_FAULT_FLAG,
  input  wire logic        FLASH_ACCESS_VIOLATION_FLAG,
  // Maskable sources, levels with flags held in their modules.
  input  wire logic        MAILBOX_OUT_FLAG,
  input  wire logic        MAILBOX_IN_FLAG,
  input  wire logic        CONVERTER_OVERFLOW_FLAG,
  input  wire logic        CONVERTER_DONE_FLAG,
  input  wire logic        WATCHDOG_INTERVAL_FLAG,
  input  wire logic        SERIAL_RX_FLAG,
  input  wire logic        SERIAL_TX_FLAG,
  input  wire logic [2:0]  CAPTURE_COMPARE_FLAG,
  input  wire logic        TIMER_OVERFLOW_FLAG,
  input  wire logic [7:0]  PORT1_PIN_FLAGS,
  input  wire logic [7:0]  PORT2_PIN_FLAGS,
  input  wire logic        BASIC_TICK_FLAG,
  // CPU core handshake.
  input  wire logic        GLOBAL_INT_ENABLE,
  input  wire logic        FETCH_VALID,
  input  wire logic [15:0] FETCH_ADDR,
  input  wire logic        IRQ_ACK,
  input  wire logic        IRQ_RETURN,
  output logic             IRQ_REQ,
  output logic [15:0]      VECTOR_ADDR,
  output logic             CPU_RESET,
  // Clock and oscillator gating.
  output logic             CPU_CLK_EN,
  output logic             MAIN_CLK_EN,
  output logic             SUB_MAIN_CLK_EN,
  output logic             AUX_CLK_EN,
  output logic             LOOP_CTL_EN,
  output logic             OSC_CLOCK_OUTPUT_EN,
  output logic             DIGITAL_OSC_BIAS_EN,
  output logic             CRYSTAL_OSC_EN
);

  // Only the implemented enable bits are stored.
  logic        osc_fault_enable_q;
  logic        ext_nonmask_enable_q;
  logic        flash_violation_enable_q;
  logic        wdt_ie_q;
  logic        urx_ie_q;
  logic        utx_ie_q;
  logic        bt_ie_q;
  op_mode_e    mode_q;
  op_mode_e    saved_mode_q;
  take_state_e state_q;
  logic [3:0]  prio_q;
  logic        fetch_rst_q;
  logic [7:0]  rdata_q;

  logic [15:0] pend;
  logic [3:0]  top_prio;
  logic        any_pend;
  logic        fetch_bad;
  logic        reset_evt;

  // Slot address for a priority number.
  function automatic word_t vec_of(input logic [3:0] p);
    vec_of = `VEC_BASE + {11'h000, p, 1'b0};
  endfunction

  // Range test used for both forbidden fetch windows.
  function automatic logic in_range(input word_t a, input word_t lo, input word_t hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Fetches from register or unused space are treated as a fatal program fault.
  assign fetch_bad = FETCH_VALID && (in_range(FETCH_ADDR, `PERIPH_LO, `PERIPH_HI) ||
                                     in_range(FETCH_ADDR, `UNUSED_LO, `UNUSED_HI));

  assign reset_evt = POWER_UP_EVT | EXT_RESET_REQ | WATCHDOG_EXPIRY_FLAG |
                     FLASH_KEY_VIOLATION_FLAG | fetch_rst_q;

  // Pending vector lines; unassigned slots 11, 7, 3 and 2 stay zero.
  always_comb
  begin
    pend     = 16'h0000;
    pend[15] = reset_evt;
    // Own enables gate this group; the global enable deliberately does not.
    pend[14] = (EXT_NONMASK_REQ_FLAG & ext_nonmask_enable_q) |
               (OSC_FAULT_FLAG & osc_fault_enable_q) |
               (FLASH_ACCESS_VIOLATION_FLAG & flash_violation_enable_q);
    pend[13] = GLOBAL_INT_ENABLE & (MAILBOX_OUT_FLAG | MAILBOX_IN_FLAG);
    pend[12] = GLOBAL_INT_ENABLE & (CONVERTER_OVERFLOW_FLAG | CONVERTER_DONE_FLAG);
    pend[10] = GLOBAL_INT_ENABLE & WATCHDOG_INTERVAL_FLAG & wdt_ie_q;
    pend[9]  = GLOBAL_INT_ENABLE & SERIAL_RX_FLAG & urx_ie_q;
    pend[8]  = GLOBAL_INT_ENABLE & SERIAL_TX_FLAG & utx_ie_q;
    pend[6]  = GLOBAL_INT_ENABLE & CAPTURE_COMPARE_FLAG[0];
    pend[5]  = GLOBAL_INT_ENABLE & (|CAPTURE_COMPARE_FLAG[2:1] | TIMER_OVERFLOW_FLAG);
    pend[4]  = GLOBAL_INT_ENABLE & (|PORT1_PIN_FLAGS);
    pend[1]  = GLOBAL_INT_ENABLE & (|PORT2_PIN_FLAGS);
    pend[0]  = GLOBAL_INT_ENABLE & BASIC_TICK_FLAG & bt_ie_q;
  end

  // Fixed-priority encoder: the highest set bit wins.
  always_comb
  begin
    top_prio = 4'h0;
    any_pend = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (pend[i])
      begin
        top_prio = 4'(i);
        any_pend = 1'b1;
      end
    end
  end

  // Bad-fetch detection is registered so the reset is clean of fetch glitches.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      fetch_rst_q <= 1'b0;
    else
      fetch_rst_q <= fetch_bad;
  end

  // Special-function enable bytes.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      osc_fault_enable_q       <= 1'b0;
      ext_nonmask_enable_q     <= 1'b0;
      flash_violation_enable_q <= 1'b0;
      wdt_ie_q                 <= 1'b0;
      urx_ie_q                 <= 1'b0;
      utx_ie_q                 <= 1'b0;
      bt_ie_q                  <= 1'b0;
    end
    else if (reset_evt)
    begin
      osc_fault_enable_q       <= 1'b0;
      ext_nonmask_enable_q     <= 1'b0;
      flash_violation_enable_q <= 1'b0;
      wdt_ie_q                 <= 1'b0;
      urx_ie_q                 <= 1'b0;
      utx_ie_q                 <= 1'b0;
      bt_ie_q                  <= 1'b0;
    end
    else if (REG_WR && REG_ADDR == `SFR_IE1_ADDR)
    begin
      wdt_ie_q                 <= REG_WDATA[`IE1_WDT_BIT];
      osc_fault_enable_q       <= REG_WDATA[`IE1_OSC_BIT];
      ext_nonmask_enable_q     <= REG_WDATA[`IE1_NMI_BIT];
      flash_violation_enable_q <= REG_WDATA[`IE1_ACCV_BIT];
      urx_ie_q                 <= REG_WDATA[`IE1_URX_BIT];
      utx_ie_q                 <= REG_WDATA[`IE1_UTX_BIT];
    end
    else if (REG_WR && REG_ADDR == `SFR_IE2_ADDR)
      bt_ie_q <= REG_WDATA[`IE2_BT_BIT];
  end

  // Take handshake: request, acknowledge, then wait for return from handler.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q <= IDLE;
      prio_q  <= 4'h0;
    end
    else if (reset_evt)
    begin
      state_q <= IDLE;
      prio_q  <= 4'hF;
    end
    else
    begin
      case (state_q)
        IDLE:
          if (any_pend)
          begin
            state_q <= TAKING;
            prio_q  <= top_prio;
          end
        TAKING:
          if (IRQ_ACK)
            state_q <= IN_HANDLER;
          else if (!any_pend)
            state_q <= IDLE;
          else
            prio_q <= top_prio; // A higher request may overtake before the ack.
        IN_HANDLER:
          if (IRQ_RETURN)
            state_q <= IDLE;
        default:
          state_q <= IDLE;
      endcase
    end
  end

  // Mode register with save on wake and restore on return.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mode_q       <= ACTIVE_STATE;
      saved_mode_q <= ACTIVE_STATE;
    end
    else if (reset_evt)
    begin
      mode_q       <= ACTIVE_STATE;
      saved_mode_q <= ACTIVE_STATE;
    end
    else if (state_q == TAKING && IRQ_ACK)
    begin
      saved_mode_q <= mode_q;
      mode_q       <= ACTIVE_STATE;
    end
    else if (state_q == IN_HANDLER && IRQ_RETURN)
      mode_q <= saved_mode_q;
    else if (REG_WR && REG_ADDR == `CTL_MODE_ADDR && REG_WDATA[2:0] <= 3'h5)
      mode_q <= op_mode_e'(REG_WDATA[2:0]);
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_q <= 8'h00;
    else if (!REG_RD)
      rdata_q <= 8'h00;
    else if (REG_ADDR == `SFR_IE1_ADDR)
      rdata_q <= {utx_ie_q, urx_ie_q, flash_violation_enable_q, ext_nonmask_enable_q,
                  2'b00, osc_fault_enable_q, wdt_ie_q};
    else if (REG_ADDR == `SFR_IE2_ADDR)
      rdata_q <= {bt_ie_q, 7'h00};
    else if (REG_ADDR == `CTL_MODE_ADDR)
      rdata_q <= {5'h00, mode_q};
    else if (REG_ADDR == `CTL_STATUS_ADDR)
      rdata_q <= {2'b00, state_q, prio_q};
    else if (REG_ADDR == `CTL_SOURCE_ADDR)
      rdata_q <= {1'b0, FLASH_ACCESS_VIOLATION_FLAG, OSC_FAULT_FLAG, EXT_NONMASK_REQ_FLAG,
                  MAILBOX_OUT_FLAG, MAILBOX_IN_FLAG, CONVERTER_OVERFLOW_FLAG,
                  CONVERTER_DONE_FLAG};
    else
      rdata_q <= 8'h00;
  end

  assign REG_RDATA = rdata_q;

  // Vector presented to the core; the handler address is fetched from it.
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      VECTOR_ADDR <= `VEC_RESET;
    else if (reset_evt)
      VECTOR_ADDR <= `VEC_RESET;
    else if (state_q == IDLE && any_pend)
      VECTOR_ADDR <= vec_of(top_prio);
    else if (state_q == TAKING && any_pend)
      VECTOR_ADDR <= vec_of(top_prio);
  end

  assign IRQ_REQ   = (state_q == TAKING);
  assign CPU_RESET = reset_evt;

  // Clock gating per mode; a deeper mode never re-enables what a lighter one stopped.
  always_comb
  begin
    CPU_CLK_EN          = 1'b1;
    MAIN_CLK_EN         = 1'b1;
    SUB_MAIN_CLK_EN     = 1'b1;
    AUX_CLK_EN          = 1'b1;
    LOOP_CTL_EN         = 1'b1;
    OSC_CLOCK_OUTPUT_EN = 1'b1;
    DIGITAL_OSC_BIAS_EN = 1'b1;
    CRYSTAL_OSC_EN      = 1'b1;
    case (mode_q)
      ACTIVE_STATE:
        CPU_CLK_EN = 1'b1;
      SLEEP_MODE_ZERO:
        CPU_CLK_EN = 1'b0;
      SLEEP_MODE_ONE:
      begin
        CPU_CLK_EN  = 1'b0;
        LOOP_CTL_EN = 1'b0;
      end
      SLEEP_MODE_TWO:
      begin
        CPU_CLK_EN          = 1'b0;
        MAIN_CLK_EN         = 1'b0;
        SUB_MAIN_CLK_EN     = 1'b0;
        LOOP_CTL_EN         = 1'b0;
        OSC_CLOCK_OUTPUT_EN = 1'b0;
      end
      SLEEP_MODE_THREE:
      begin
        CPU_CLK_EN          = 1'b0;
        MAIN_CLK_EN         = 1'b0;
        SUB_MAIN_CLK_EN     = 1'b0;
        LOOP_CTL_EN         = 1'b0;
        OSC_CLOCK_OUTPUT_EN = 1'b0;
        DIGITAL_OSC_BIAS_EN = 1'b0;
      end
      SLEEP_MODE_FOUR:
      begin
        CPU_CLK_EN          = 1'b0;
        MAIN_CLK_EN         = 1'b0;
        SUB_MAIN_CLK_EN     = 1'b0;
        AUX_CLK_EN          = 1'b0;
        LOOP_CTL_EN         = 1'b0;
        OSC_CLOCK_OUTPUT_EN = 1'b0;
        DIGITAL_OSC_BIAS_EN = 1'b0;
        CRYSTAL_OSC_EN      = 1'b0;
      end
      default:
        CPU_CLK_EN = 1'b1;
    endcase
  end

endmodule

// ---- interrupt_vector_lowpower_ctl_properties.sv ----
`timescale 1ns/1ps
// Watches vector, wake, clock gating and reset relations at the controller's ports.
module irq_ctl_checker (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        POWER_UP_EVT,
  input wire logic        EXT_RESET_REQ,
  input wire logic        WATCHDOG_EXPIRY_FLAG,
  input wire logic        FLASH_KEY_VIOLATION_FLAG,
  input wire logic        FETCH_VALID,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic        IRQ_ACK,
  input wire logic        IRQ_REQ,
  input wire logic [15:0] VECTOR_ADDR,
  input wire logic        CPU_RESET,
  input wire logic        CPU_CLK_EN,
  input wire logic        MAIN_CLK_EN,
  input wire logic        SUB_MAIN_CLK_EN,
  input wire logic        AUX_CLK_EN,
  input wire logic        LOOP_CTL_EN,
  input wire logic        OSC_CLOCK_OUTPUT_EN,
  input wire logic        DIGITAL_OSC_BIAS_EN,
  input wire logic        CRYSTAL_OSC_EN
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  // Shared terms, so each property reads as one relation.
  logic       cause;
  logic       bad;
  logic [7:0] clk_en;
  assign cause = POWER_UP_EVT | EXT_RESET_REQ | WATCHDOG_EXPIRY_FLAG | FLASH_KEY_VIOLATION_FLAG;
  assign bad = FETCH_VALID && (FETCH_ADDR <= 16'h01FF || (FETCH_ADDR >= 16'h0600 && FETCH_ADDR <= 16'h0BFF));
  assign clk_en = {CPU_CLK_EN, MAIN_CLK_EN, SUB_MAIN_CLK_EN, AUX_CLK_EN,
                   LOOP_CTL_EN, OSC_CLOCK_OUTPUT_EN, DIGITAL_OSC_BIAS_EN, CRYSTAL_OSC_EN};

  // The core accepts the offered vector.
  sequence take_s;
    IRQ_REQ && IRQ_ACK;
  endsequence

  a_vec_legal: assert property (IRQ_REQ |-> VECTOR_ADDR >= 16'hFFE0 && !VECTOR_ADDR[0] &&
    !(VECTOR_ADDR inside {16'hFFE4, 16'hFFE6, 16'hFFEE, 16'hFFF6, 16'hFFFE})) else $error("illegal vector offered");
  a_ack_drops: assert property (take_s |=> !IRQ_REQ) else $error("request held after ack");
  a_ack_wakes: assert property (take_s |=> clk_en == 8'hFF) else $error("no wake on take");
  a_fetch_reset: assert property (bad |=> CPU_RESET) else $error("bad fetch without reset");
  a_cause_reset: assert property (cause |-> CPU_RESET) else $error("reset cause ignored");
  a_cause_vector: assert property (cause |=> VECTOR_ADDR == 16'hFFFE) else $error("reset vector wrong");
  a_active_all: assert property (CPU_CLK_EN |-> clk_en == 8'hFF) else $error("clock off while active");
  a_bias_chain: assert property (!DIGITAL_OSC_BIAS_EN |-> clk_en[7:6] == 2'b00 && clk_en[3:2] == 2'b00)
    else $error("bias off with clocks on");
endmodule

// ---- cpu_core_model.sv ----
`timescale 1ns/1ps
// Core side: takes an offered vector after a chosen delay, runs a short handler, then returns.
module cpu_core_model #(
  parameter int HANDLER_LEN = 8
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        IRQ_REQ,
  input  wire logic [15:0] VECTOR_ADDR,
  input  wire logic [3:0]  ack_delay,
  output logic             IRQ_ACK,
  output logic             IRQ_RETURN,
  output logic      [15:0] taken_vec,
  output logic      [7:0]  take_count
);
  logic       busy_q;
  logic [3:0] cnt_q;

  // Acknowledge is a single pulse, so one offer is never taken twice.
  always @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      {IRQ_ACK, IRQ_RETURN, busy_q, cnt_q, taken_vec, take_count} <= '0;
    else
    begin
      IRQ_ACK <= 1'b0;
      IRQ_RETURN <= 1'b0;
      cnt_q <= cnt_q + 4'h1;
      if (busy_q && cnt_q == 4'(HANDLER_LEN))
      begin
        IRQ_RETURN <= 1'b1;
        busy_q <= 1'b0;
      end
      else if (!busy_q && !IRQ_REQ)
        cnt_q <= 4'h0;
      else if (!busy_q && cnt_q >= ack_delay)
      begin
        IRQ_ACK <= 1'b1;
        taken_vec <= VECTOR_ADDR;
        take_count <= take_count + 8'h01;
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
      end
    end
  end
endmodule

// ---- tb_interrupt_vector_lowpower_ctl.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin total_checks++; if ((gt) !== (ex)) begin miscompares++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end

module tb_interrupt_vector_lowpower_ctl;
  typedef struct packed {logic [16:0] s; logic gie; logic [15:0] v;} row_s;
  logic        CORE_CLK, SYS_RST, REG_WR, REG_RD, GLOBAL_INT_ENABLE, FETCH_VALID, IRQ_ACK, IRQ_RETURN;
  logic [15:0] REG_ADDR, FETCH_ADDR, VECTOR_ADDR, taken_vec, got;
  logic [7:0]  REG_WDATA, REG_RDATA, PORT1_PIN_FLAGS, PORT2_PIN_FLAGS, take_count, clk_en, rd, n0;
  logic [2:0]  CAPTURE_COMPARE_FLAG;
  logic        POWER_UP_EVT, EXT_RESET_REQ, WATCHDOG_EXPIRY_FLAG, FLASH_KEY_VIOLATION_FLAG, EXT_NONMASK_REQ_FLAG;
  logic        OSC_FAULT_FLAG, FLASH_ACCESS_VIOLATION_FLAG, MAILBOX_OUT_FLAG, MAILBOX_IN_FLAG, CONVERTER_OVERFLOW_FLAG;
  logic        CONVERTER_DONE_FLAG, WATCHDOG_INTERVAL_FLAG, SERIAL_RX_FLAG, SERIAL_TX_FLAG, TIMER_OVERFLOW_FLAG;
  logic        BASIC_TICK_FLAG, IRQ_REQ, CPU_RESET, CPU_CLK_EN, MAIN_CLK_EN, SUB_MAIN_CLK_EN, AUX_CLK_EN;
  logic        LOOP_CTL_EN, OSC_CLOCK_OUTPUT_EN, DIGITAL_OSC_BIAS_EN, CRYSTAL_OSC_EN;
  logic [16:0] src;
  logic [3:0]  rst_src, ack_delay;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Single sources first, then masking and contention between levels.
  row_s rows [20] = '{
    '{17'h00001, 1'b0, 16'hFFFC}, '{17'h00002, 1'b0, 16'hFFFC}, '{17'h00004, 1'b0, 16'hFFFC},
    '{17'h00008, 1'b1, 16'hFFFA}, '{17'h00010, 1'b1, 16'hFFFA}, '{17'h00020, 1'b1, 16'hFFF8},
    '{17'h00040, 1'b1, 16'hFFF8}, '{17'h00080, 1'b1, 16'hFFF4}, '{17'h00100, 1'b1, 16'hFFF2},
    '{17'h00200, 1'b1, 16'hFFF0}, '{17'h00400, 1'b1, 16'hFFEC}, '{17'h00800, 1'b1, 16'hFFEA},
    '{17'h01000, 1'b1, 16'hFFEA}, '{17'h02000, 1'b1, 16'hFFEA}, '{17'h04000, 1'b1, 16'hFFE8},
    '{17'h08000, 1'b1, 16'hFFE2}, '{17'h10000, 1'b1, 16'hFFE0}, '{17'h1FFF8, 1'b0, 16'h0000},
    '{17'h1FFF8, 1'b1, 16'hFFFA}, '{17'h18000, 1'b1, 16'hFFE2}};
  logic [7:0]  mode_en [7] = '{8'hFF, 8'h7F, 8'h77, 8'h13, 8'h11, 8'h00, 8'h00};
  logic [15:0] fa [6] = '{16'h0000, 16'h01FF, 16'h0200, 16'h0600, 16'h0BFF, 16'h0C00};
  logic        fx [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  // Port flags are spread over all pins so every pin of a group is driven.
  assign {BASIC_TICK_FLAG, PORT2_PIN_FLAGS, PORT1_PIN_FLAGS, TIMER_OVERFLOW_FLAG, CAPTURE_COMPARE_FLAG, SERIAL_TX_FLAG,
          SERIAL_RX_FLAG, WATCHDOG_INTERVAL_FLAG, CONVERTER_DONE_FLAG, CONVERTER_OVERFLOW_FLAG, MAILBOX_IN_FLAG,
          MAILBOX_OUT_FLAG, FLASH_ACCESS_VIOLATION_FLAG, OSC_FAULT_FLAG, EXT_NONMASK_REQ_FLAG}
         = {src[16], {8{src[15]}}, {8{src[14]}}, src[13:0]};
  assign {POWER_UP_EVT, EXT_RESET_REQ, WATCHDOG_EXPIRY_FLAG, FLASH_KEY_VIOLATION_FLAG} = rst_src;
  assign clk_en = {CPU_CLK_EN, MAIN_CLK_EN, SUB_MAIN_CLK_EN, AUX_CLK_EN,
                   LOOP_CTL_EN, OSC_CLOCK_OUTPUT_EN, DIGITAL_OSC_BIAS_EN, CRYSTAL_OSC_EN};

  interrupt_vector_lowpower_ctl i_interrupt_vector_lowpower_ctl (.*);
  cpu_core_model i_cpu_core_model (.*);

  // Free-running core clock.
  initial
  begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // A stuck handshake would otherwise stall the run.
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
    @(posedge CORE_CLK);
  endtask

  // Polls after the edge so the model's counter has settled.
  task automatic take_wait();
    n0 = take_count;
    for (int k = 0; k < 20 && take_count == n0; k++)
    begin
      @(posedge CORE_CLK);
      #1;
    end
    @(posedge CORE_CLK);
  endtask

  // Main sequence.
  initial
  begin
    SYS_RST = 1'b1;
    {REG_WR, REG_RD, GLOBAL_INT_ENABLE, FETCH_VALID, ack_delay, rst_src, src} = '0;
    {REG_ADDR, REG_WDATA, FETCH_ADDR} = '0;
    repeat (8) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    @(posedge CORE_CLK);
    reg_rd(16'h0000, rd);
    `CHK("ie1 reset", 8'h00, rd)
    `CHK("clocks reset", 8'hFF, clk_en)
    reg_wr(16'h0000, 8'hFF);
    // One idle edge keeps the write strobe from being driven twice in one step.
    @(posedge CORE_CLK);
    reg_wr(16'h0001, 8'hFF);
    reg_rd(16'h0000, rd);
    `CHK("ie1", 8'hF3, rd)
    reg_rd(16'h0001, rd);
    `CHK("ie2", 8'h80, rd)
    reg_rd(16'h0030, rd);
    `CHK("unmapped", 8'h00, rd)
    for (int m = 0; m < 7; m++)
    begin
      reg_wr(16'h0010, 8'(m));
      #1;
      `CHK("clock gates", mode_en[m], clk_en)
      @(posedge CORE_CLK);
      reg_rd(16'h0010, rd);
      `CHK("mode readback", ((m > 5) ? 8'h05 : 8'(m)), rd)
    end
    $display("test registers and modes done");
    reg_wr(16'h0010, 8'h04);
    GLOBAL_INT_ENABLE <= 1'b1;
    src <= 17'h04000;
    take_wait();
    #1;
    `CHK("awake", 8'hFF, clk_en)
    @(posedge CORE_CLK);
    src <= '0;
    repeat (14) @(posedge CORE_CLK);
    #1;
    `CHK("asleep again", 8'h11, clk_en)
    @(posedge CORE_CLK);
    reg_wr(16'h0010, 8'h00);
    $display("test wake done");
    foreach (rows[i])
    begin
      ack_delay <= 4'(i % 4);
      GLOBAL_INT_ENABLE <= rows[i].gie;
      src <= rows[i].s;
      take_wait();
      got = (take_count == n0) ? 16'h0000 : taken_vec;
      src <= '0;
      `CHK("vector", rows[i].v, got)
      repeat (14) @(posedge CORE_CLK);
    end
    $display("test vectors done");
    // The top group obeys its own enables even with the global enable set.
    reg_wr(16'h0000, 8'h00);
    src <= 17'h00007;
    take_wait();
    `CHK("masked top group", n0, take_count)
    reg_rd(16'h0014, rd);
    `CHK("source readback", 8'h70, rd)
    src <= '0;
    foreach (fa[i])
    begin
      FETCH_ADDR <= fa[i];
      FETCH_VALID <= 1'b1;
      @(posedge CORE_CLK);
      FETCH_VALID <= 1'b0;
      #1;
      `CHK("fetch reset", fx[i], CPU_RESET)
      @(posedge CORE_CLK);
    end
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(16'h0000, 8'hFF);
      rst_src <= 4'(1 << k);
      #1;
      `CHK("reset line", 1'b1, CPU_RESET)
      @(posedge CORE_CLK);
      rst_src <= 4'h0;
      #1;
      `CHK("reset vector", 16'hFFFE, VECTOR_ADDR)
      @(posedge CORE_CLK);
      reg_rd(16'h0000, rd);
      `CHK("ie1 cleared", 8'h00, rd)
    end
    $display("test resets done");
    close_out();
  end
endmodule

bind interrupt_vector_lowpower_ctl irq_ctl_checker i_irq_ctl_checker (.*);
